// ===== src/ftrr_pkg.sv
// Package with constants and carrier types for the fault and translation result registers.
package ftrr_pkg;
  // Coprocessor access encoding of the instruction fault status register.
  localparam logic [3:0] IFS_CRN = 4'h5;
  localparam logic [2:0] IFS_OPC2 = 3'h1;
  localparam logic [3:0] IFS_CRM = 4'h0;
  localparam logic [2:0] IFS_OPC1 = 3'h0;
  // Coprocessor 64-bit access encoding of the translation result register.
  localparam logic [3:0] TR_OPC1 = 4'h0;
  localparam logic [3:0] TR_CRM = 4'h7;
  // Instruction fault status field positions.
  localparam int IFS_FNV_BIT = 16;
  localparam int IFS_EXT_BIT = 12;
  localparam int IFS_LONG_BIT = 9;
  // Fault status codes.
  localparam logic [5:0] FS_TRANSLATION = 6'h04;
  localparam logic [5:0] FS_PERMISSION = 6'h0C;
  localparam logic [5:0] FS_SYNC_EXT = 6'h10;
  localparam logic [5:0] FS_PARITY = 6'h18;
  localparam logic [5:0] FS_PC_ALIGN = 6'h21;
  localparam logic [5:0] FS_DEBUG = 6'h22;
  // Translation result field positions.
  localparam int TR_F_BIT = 0;
  localparam int TR_LONG_BIT = 11;
  localparam int TR_STAGE_BIT = 9;
  localparam int TR_WALK_BIT = 8;
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_RSVD = 2'h1;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] SH_INNER = 2'h3;
  localparam logic [31:0] IFS_RESET = 32'h0000_0000;
  localparam logic [63:0] TR_RESET = 64'h0000_0000_0000_0000;

  // Instruction fetch fault report from the pipeline.
  typedef struct packed {
    logic valid;
    logic [5:0] code;
    logic ext_type;
    logic addr_invalid;
  } ftrr_ifault_t;

  // Address translation result from the walker.
  typedef struct packed {
    logic valid;
    logic aborted;
    logic [7:0] attr;
    logic [27:0] out_addr;
    logic [1:0] share;
    logic device_mem;
    logic noncache;
    logic stage2;
    logic s2_walk;
    logic [5:0] code;
  } ftrr_xlat_t;

  // Coprocessor access request.
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [63:0] wdata;
    logic priv_one;
  } ftrr_cpreq_t;

  // Hypervisor trap controls.
  typedef struct packed {
    logic hyp_present;
    logic vm_write_trap;
    logic vm_read_trap;
    logic reg_group_five_trap;
    logic reg_group_seven_trap;
  } ftrr_trapctl_t;
endpackage : ftrr_pkg

// ===== src/ftrr_regs.sv
// Instruction fault status and translation result registers.
//
// Contract
// - Latch the cause of each taken instruction-fetch fault.
// - Bit 16 set when fault address invalid on a synchronous external or parity abort.
// - Fault-address-invalid bit reads zero for all other aborts.
// - Bit 12 holds external abort type, zero for non-external aborts.
// - Codes: translation 000100, permission 001100, external abort 010000.
// - Codes: parity 011000, PC alignment 100001, debug 100010.
// - Trap fault status writes from level one when write trap set.
// - Trap fault status reads from level one when read trap set.
// - Group-five trap bit traps every level-one fault status access.
// - Group-seven trap bit traps every level-one translation result access.
// - Bit 0 is 0 on success, 1 on aborted translation.
// - Success puts memory attributes in bits 63 to 56.
// - Success puts output address bits 39 to 12.
// - Bit 11 set on every hardware update.
// - Shareability 00, 10 or 11; never 01.
// - Device or fully non-cacheable memory reports shareability 10.
// - Security-state bit is unknown after success; driven zero here.
// - Software writes are stored with no other effect.
// - Bit 9 on abort selects stage 1 or stage 2.
// - Bit 8 on abort marks stage 2 fault during stage 1 walk.
// - Bits 6 to 1 on abort hold the fault code.
`timescale 1ns/1ps
`default_nettype none
module ftrr_regs (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire ftrr_pkg::ftrr_ifault_t IFAULT,
  input wire ftrr_pkg::ftrr_xlat_t XLAT,
  input wire ftrr_pkg::ftrr_cpreq_t CPREQ,
  input wire ftrr_pkg::ftrr_trapctl_t TRAPCTL,
  output logic CP_ACK,
  output logic CP_TRAP,
  output logic [63:0] CP_RDATA,
  output logic [31:0] INSTRUCTION_FAULT_STATUS,
  output logic [63:0] TRANSLATION_RESULT
);
  logic [31:0] ifs_reg;
  logic [63:0] tr_reg;
  logic [31:0] ifs_next;
  logic [63:0] tr_next;
  logic [1:0] share_next;
  logic hit_ifs;
  logic hit_tr;
  logic trap_ifs;
  logic trap_tr;

  // Known fault status codes; anything else is stored as 000000.
  function automatic logic fs_known(input logic [5:0] c);
    return c == ftrr_pkg::FS_TRANSLATION || c == ftrr_pkg::FS_PERMISSION ||
           c == ftrr_pkg::FS_SYNC_EXT || c == ftrr_pkg::FS_PARITY ||
           c == ftrr_pkg::FS_PC_ALIGN || c == ftrr_pkg::FS_DEBUG;
  endfunction : fs_known

  // External abort codes, used by the type bit.
  function automatic logic fs_external(input logic [5:0] c);
    return c == ftrr_pkg::FS_SYNC_EXT || c == ftrr_pkg::FS_PARITY;
  endfunction : fs_external

  // Coprocessor register decode.
  always_comb begin
    hit_ifs = CPREQ.valid && !CPREQ.wide &&
      CPREQ.opc1 == ftrr_pkg::IFS_OPC1 && CPREQ.crn == ftrr_pkg::IFS_CRN &&
      CPREQ.crm == ftrr_pkg::IFS_CRM && CPREQ.opc2 == ftrr_pkg::IFS_OPC2;
    hit_tr = CPREQ.valid && CPREQ.wide &&
      {1'b0, CPREQ.opc1} == ftrr_pkg::TR_OPC1 &&
      CPREQ.crm == ftrr_pkg::TR_CRM;
  end

  // Hypervisor trap decision for level-one accesses.
  always_comb begin
    trap_ifs = hit_ifs && CPREQ.priv_one && TRAPCTL.hyp_present &&
      ((CPREQ.write && TRAPCTL.vm_write_trap) ||
       (!CPREQ.write && TRAPCTL.vm_read_trap) ||
       TRAPCTL.reg_group_five_trap);
    trap_tr = hit_tr && CPREQ.priv_one && TRAPCTL.hyp_present &&
      TRAPCTL.reg_group_seven_trap;
  end

  // Next fault status value from a taken instruction fault.
  always_comb begin
    ifs_next = 32'h0000_0000;
    ifs_next[5:0] = fs_known(IFAULT.code) ? IFAULT.code : 6'h00;
    ifs_next[ftrr_pkg::IFS_LONG_BIT] = 1'b1;
    ifs_next[ftrr_pkg::IFS_FNV_BIT] = (IFAULT.code == ftrr_pkg::FS_SYNC_EXT ||
      IFAULT.code == ftrr_pkg::FS_PARITY) && IFAULT.addr_invalid;
    ifs_next[ftrr_pkg::IFS_EXT_BIT] = fs_external(IFAULT.code) &&
      IFAULT.ext_type;
  end

  // Shareability reported with a successful translation.
  always_comb begin
    if (XLAT.device_mem || XLAT.noncache) begin
      share_next = ftrr_pkg::SH_OUTER;
    end else if (XLAT.share == ftrr_pkg::SH_RSVD) begin
      share_next = ftrr_pkg::SH_NONE;
    end else begin
      share_next = XLAT.share;
    end
  end

  // Next translation result value in the long layout.
  always_comb begin
    tr_next = 64'h0000_0000_0000_0000;
    tr_next[ftrr_pkg::TR_LONG_BIT] = 1'b1;
    tr_next[ftrr_pkg::TR_F_BIT] = XLAT.aborted;
    if (XLAT.aborted) begin
      tr_next[ftrr_pkg::TR_STAGE_BIT] = XLAT.stage2;
      tr_next[ftrr_pkg::TR_WALK_BIT] = XLAT.s2_walk;
      tr_next[6:1] = XLAT.code;
    end else begin
      tr_next[63:56] = XLAT.attr;
      tr_next[39:12] = XLAT.out_addr;
      tr_next[8:7] = share_next;
    end
  end

  // Fault status register; a taken fault wins over a same-cycle write.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ifs_reg <= ftrr_pkg::IFS_RESET;
    end else if (CE) begin
      if (IFAULT.valid) begin
        ifs_reg <= ifs_next;
      end else if (hit_ifs && CPREQ.write && !trap_ifs) begin
        ifs_reg <= CPREQ.wdata[31:0];
      end
    end
  end

  // Translation result register; a result wins over a same-cycle write.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tr_reg <= ftrr_pkg::TR_RESET;
    end else if (CE) begin
      if (XLAT.valid) begin
        tr_reg <= tr_next;
      end else if (hit_tr && CPREQ.write && !trap_tr) begin
        tr_reg <= CPREQ.wdata;
      end
    end
  end

  // Access answer one cycle after the request.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CP_ACK <= 1'b0;
      CP_TRAP <= 1'b0;
      CP_RDATA <= 64'h0000_0000_0000_0000;
    end else if (CE) begin
      CP_ACK <= hit_ifs || hit_tr;
      CP_TRAP <= trap_ifs || trap_tr;
      if (hit_ifs && !CPREQ.write && !trap_ifs) begin
        CP_RDATA <= {32'h0000_0000, ifs_reg};
      end else if (hit_tr && !CPREQ.write && !trap_tr) begin
        CP_RDATA <= tr_reg;
      end else begin
        CP_RDATA <= 64'h0000_0000_0000_0000;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      INSTRUCTION_FAULT_STATUS <= ftrr_pkg::IFS_RESET;
      TRANSLATION_RESULT <= ftrr_pkg::TR_RESET;
    end else if (CE) begin
      INSTRUCTION_FAULT_STATUS <= ifs_reg;
      TRANSLATION_RESULT <= tr_reg;
    end
  end
endmodule : ftrr_regs
`default_nettype wire

// ===== testbench/ftrr_regs_sva.sv
// Assertions on the fault status and translation result registers.
`timescale 1ns/1ps
`default_nettype none
module ftrr_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire ftrr_pkg::ftrr_ifault_t IFAULT,
  input wire ftrr_pkg::ftrr_xlat_t XLAT,
  input wire ftrr_pkg::ftrr_cpreq_t CPREQ,
  input wire ftrr_pkg::ftrr_trapctl_t TRAPCTL,
  input wire logic CP_ACK,
  input wire logic CP_TRAP,
  input wire logic [63:0] CP_RDATA,
  input wire logic [31:0] INSTRUCTION_FAULT_STATUS,
  input wire logic [63:0] TRANSLATION_RESULT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic fs, tr, lv, xv, xq;
  assign fs = CE && CPREQ.valid && !CPREQ.wide && CPREQ.crn == 4'h5 &&
    CPREQ.opc1 == 3'h0 && CPREQ.crm == 4'h0 && CPREQ.opc2 == 3'h1;
  assign tr = CE && CPREQ.valid && CPREQ.wide && CPREQ.crm == 4'h7 &&
    CPREQ.opc1 == 3'h0;
  assign lv = TRAPCTL.hyp_present && CPREQ.priv_one;
  assign xv = CE && XLAT.valid;
  assign xq = CE && !XLAT.valid;
  fs_ack_a:
    assert property (fs |=> CP_ACK) else $error("no ack");
  wr_trap_a:
    assert property (fs && lv && CPREQ.write && TRAPCTL.vm_write_trap
      |=> CP_TRAP) else $error("write not trapped");
  rd_trap_a:
    assert property (fs && lv && !CPREQ.write && TRAPCTL.vm_read_trap
      |=> CP_TRAP && CP_RDATA == 64'h0) else $error("read not trapped");
  g5_trap_a:
    assert property (fs && lv && TRAPCTL.reg_group_five_trap |=> CP_TRAP)
      else $error("group five");
  g7_trap_a:
    assert property (tr && lv && TRAPCTL.reg_group_seven_trap |=> CP_TRAP)
      else $error("group seven");
  xl_flag_a:
    assert property (xv ##1 xq |=> TRANSLATION_RESULT[11] &&
      TRANSLATION_RESULT[0] == $past(XLAT.aborted, 2)) else $error("flags");
  ok_field_a:
    assert property (xv && !XLAT.aborted ##1 xq |=> TRANSLATION_RESULT[63:12]
      == {$past(XLAT.attr, 2), 16'h0, $past(XLAT.out_addr, 2)})
      else $error("success layout");
  ab_field_a:
    assert property (xv && XLAT.aborted ##1 xq |=> TRANSLATION_RESULT[9:1]
      == {$past(XLAT.stage2, 2), $past(XLAT.s2_walk, 2), 1'b0,
      $past(XLAT.code, 2)}) else $error("abort layout");
  cover property (tr ##1 CP_ACK);
  cover property (xv && XLAT.aborted);
  cover property (CE && IFAULT.valid);
endmodule : ftrr_chk
bind ftrr_regs ftrr_chk i_ftrr_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .IFAULT(IFAULT), .XLAT(XLAT), .CPREQ(CPREQ), .TRAPCTL(TRAPCTL),
  .CP_ACK(CP_ACK), .CP_TRAP(CP_TRAP), .CP_RDATA(CP_RDATA),
  .INSTRUCTION_FAULT_STATUS(INSTRUCTION_FAULT_STATUS),
  .TRANSLATION_RESULT(TRANSLATION_RESULT));
`default_nettype wire

// ===== testbench/ftrr_sw_model.sv
// Software side model that encodes coprocessor requests.
`timescale 1ns/1ps
`default_nettype none
module ftrr_sw_model (
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic wr,
  input wire logic priv,
  input wire logic [63:0] wdata,
  output ftrr_pkg::ftrr_cpreq_t req
);
  always_comb begin
    req = '{go, wr, kind == 2'h1, 3'h0, kind == 2'h0 ? 4'h5 : 4'h6,
      kind == 2'h1 ? 4'h7 : 4'h0, 3'h1, go ? wdata : ~wdata, priv};
  end
endmodule : ftrr_sw_model
`default_nettype wire

// ===== testbench/tb.sv
// Testbench for the fault status and translation result registers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [63:0] PV = 64'h8000_0000_0000_0080;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, wr = 1'b0, priv = 1'b1;
  logic ack, trap;
  logic ce = 1'b1;
  logic [31:0] ifs_o;
  logic [63:0] tr_o;
  logic [1:0] kind = 2'h0;
  logic [63:0] wd = 64'h0, rd;
  logic [5:0] codes [6] = '{6'h04, 6'h0C, 6'h10, 6'h18, 6'h21, 6'h22};
  ftrr_pkg::ftrr_ifault_t flt = '0;
  ftrr_pkg::ftrr_xlat_t xl = '0;
  ftrr_pkg::ftrr_trapctl_t tc = '0;
  ftrr_pkg::ftrr_cpreq_t req;
  int error_cnt = 0, checks_done = 0;
  always #50 clk = ~clk;
  ftrr_sw_model i_ftrr_sw_model (.go(go), .kind(kind), .wr(wr), .priv(priv),
    .wdata(wd), .req(req));
  ftrr_regs i_ftrr_regs (.CLK(clk), .RESETN(rstn), .CE(ce), .IFAULT(flt),
    .XLAT(xl), .CPREQ(req), .TRAPCTL(tc), .CP_ACK(ack), .CP_TRAP(trap),
    .CP_RDATA(rd), .INSTRUCTION_FAULT_STATUS(ifs_o),
    .TRANSLATION_RESULT(tr_o));
  task cp(input logic [1:0] k, input logic w, input logic [63:0] d,
    input logic [1:0] at, input logic [63:0] e, input logic [63:0] m);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    wr <= w;
    wd <= d;
    @(posedge clk);
    go <= 1'b0;
    #1;
    checks_done++;
    if ({ack, trap} !== at || (rd & m) !== e) begin
      error_cnt++;
      $display("wrong value reply expected %h %h seen %h %h", at, e,
        {ack, trap}, rd);
    end
  endtask : cp
  task t_fault;
    logic x;
    for (int i = 0; i < 6; i++) begin
      x = codes[i] == 6'h10 || codes[i] == 6'h18;
      @(posedge clk);
      flt <= '{1'b1, codes[i], 1'b1, i[0]};
      @(posedge clk);
      flt <= '0;
      cp(2'h0, 1'b0, 64'h0, 2'h2, {47'h0, x & i[0], 3'h0, x, 3'h1, 3'h0,
        codes[i]}, '1);
    end
    $display("fault test done");
  endtask : t_fault
  task t_xlat;
    logic [1:0] s;
    for (int i = 0; i < 5; i++) begin
      s = (i > 2) ? 2'h2 : (i == 1) ? 2'h0 : i[1:0];
      @(posedge clk);
      xl <= '{1'b1, 1'b0, 8'hA5 ^ i[7:0], 28'h9ABCDEF, i[1:0], i == 4,
        i == 3, 1'b1, 1'b1, 6'h3F};
      @(posedge clk);
      xl <= '0;
      cp(2'h1, 1'b0, 64'h0, 2'h2, {8'hA5 ^ i[7:0], 16'h0, 28'h9ABCDEF, 3'h4,
        s, 7'h0}, ~64'h200);
    end
    @(posedge clk);
    xl <= '{1'b1, 1'b1, 8'hFF, 28'hFFFFFFF, 2'h3, 1'b1, 1'b1, 1'b1, 1'b1,
      6'h0C};
    @(posedge clk);
    xl <= '0;
    cp(2'h1, 1'b0, 64'h0, 2'h2, 64'hB19, '1);
    $display("translation test done");
  endtask : t_xlat
  task t_write;
    cp(2'h1, 1'b1, PV, 2'h2, 64'h0, 64'h0);
    cp(2'h1, 1'b0, 64'h0, 2'h2, PV, '1);
    cp(2'h0, 1'b1, 64'h11210, 2'h2, 64'h0, 64'h0);
    cp(2'h0, 1'b0, 64'h0, 2'h2, 64'h11210, '1);
    cp(2'h2, 1'b0, 64'h0, 2'h0, 64'h0, '1);
    $display("write test done");
  endtask : t_write
  task t_trap;
    tc <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    cp(2'h0, 1'b1, 64'h4, 2'h3, 64'h0, '1);
    cp(2'h0, 1'b0, 64'h0, 2'h2, 64'h11210, '1);
    tc <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    cp(2'h0, 1'b0, 64'h0, 2'h3, 64'h0, '1);
    tc <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    cp(2'h0, 1'b1, 64'h4, 2'h3, 64'h0, '1);
    cp(2'h1, 1'b1, 64'h4, 2'h3, 64'h0, '1);
    priv <= 1'b0;
    cp(2'h1, 1'b0, 64'h0, 2'h2, PV, '1);
    priv <= 1'b1;
    tc <= '0;
    cp(2'h0, 1'b0, 64'h0, 2'h2, 64'h11210, '1);
    $display("trap test done");
  endtask : t_trap
  task t_hold;
    @(posedge clk);
    ce <= 1'b0;
    flt <= '{1'b1, 6'h04, 1'b0, 1'b0};
    cp(2'h0, 1'b0, 64'h0, 2'h0, 64'h0, '1);
    @(posedge clk);
    flt <= '0;
    ce <= 1'b1;
    cp(2'h0, 1'b0, 64'h0, 2'h2, 64'h11210, '1);
    checks_done++;
    if (ifs_o !== 32'h0001_1210) begin
      error_cnt++;
      $display("wrong value fault status copy expected %h seen %h",
        32'h0001_1210, ifs_o);
    end
    checks_done++;
    if (tr_o !== PV) begin
      error_cnt++;
      $display("wrong value result copy expected %h seen %h", PV, tr_o);
    end
    $display("hold test done");
  endtask : t_hold
  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_fault;
    t_xlat;
    t_write;
    t_trap;
    t_hold;
    results;
  end
endmodule : tb
`default_nettype wire
